/* src/dsdu_acc_file.sv */
// four-word accumulator store with registered read ports
`timescale 1ns/100ps
module dsdu_acc_file
  import dsdu_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        load_all,
  input  wire logic [15:0] load_acc_zero,
  input  wire logic [15:0] load_acc_one,
  input  wire logic [15:0] load_acc_two,
  input  wire logic [15:0] load_acc_three,
  input  wire logic        wr_en,
  input  wire logic [1:0]  wr_sel,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] acc_zero_ff,
  output logic      [15:0] acc_one_ff,
  output logic      [15:0] acc_two_ff,
  output logic      [15:0] acc_three_ff
);
  logic [15:0] nxt_acc [4];

  always_comb
  begin
    nxt_acc[0] = acc_zero_ff;
    nxt_acc[1] = acc_one_ff;
    nxt_acc[2] = acc_two_ff;
    nxt_acc[3] = acc_three_ff;
    if (load_all)
    begin
      nxt_acc[0] = load_acc_zero;
      nxt_acc[1] = load_acc_one;
      nxt_acc[2] = load_acc_two;
      nxt_acc[3] = load_acc_three;
    end
    else if (wr_en)
    begin
      nxt_acc[wr_sel] = wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_zero_ff  <= 16'h0000;
      acc_one_ff   <= 16'h0000;
      acc_two_ff   <= 16'h0000;
      acc_three_ff <= 16'h0000;
    end
    else
    begin
      acc_zero_ff  <= nxt_acc[0];
      acc_one_ff   <= nxt_acc[1];
      acc_two_ff   <= nxt_acc[2];
      acc_three_ff <= nxt_acc[3];
    end
  end
endmodule

/* src/dsdu_core.sv */
// decimal add, double hex shift and divide datapath
//
// Function
// RL1 - decimal add low digits plus carry
// RL2 - decimal add keeps source, upper twelve bits
// RL3 - software supplies only digits zero to nine
// RL4 - hex left shift, zero fill low
// RL5 - hex right shift, zero fill high
// RL6 - two-bit count field means one to four
// RL7 - accumulator three pairs with accumulator zero
// RL8 - named accumulator holds most significant half
// RL9 - four-digit shift moves whole word, clears other
// RL10 - unsigned divide: quotient one, remainder zero
// RL11 - unsigned overflow check first, operands kept
// RL12 - signed divide of pair by accumulator two
// RL13 - algebraic quotient sign, remainder follows dividend
// RL14 - signed quotient overflow sets carry, terminates
// RL15 - sign-extend accumulator one into zero, divide
// RL16 - bit zero is most significant bit
// RL17 - signal completion after results or overflow
`timescale 1ns/100ps
`include "dsdu_defs.svh"
module dsdu_core
  import dsdu_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        start,
  input  wire dsdu_op_t    op,
  input  wire logic [1:0]  src_sel,
  input  wire logic [1:0]  dst_sel,
  input  wire logic [1:0]  shift_code,
  input  wire logic [15:0] in_acc_zero,
  input  wire logic [15:0] in_acc_one,
  input  wire logic [15:0] in_acc_two,
  input  wire logic [15:0] in_acc_three,
  input  wire logic        in_carry,
  output logic      [15:0] acc_zero_ff,
  output logic      [15:0] acc_one_ff,
  output logic      [15:0] acc_two_ff,
  output logic      [15:0] acc_three_ff,
  output logic             carry_ff,
  output logic             busy_ff,
  output logic             done_ff
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // RL16 msb-first bit numbering
  // word bit zero is vector index [15], bit fifteen is [0]
  function automatic logic [15:0] pick(input logic [1:0] sel, input logic [15:0] a0,
                                       input logic [15:0] a1, input logic [15:0] a2,
                                       input logic [15:0] a3);
    logic [15:0] r;
    r = a0;
    case (sel)
      2'h0: r = a0;
      2'h1: r = a1;
      2'h2: r = a2;
      default: r = a3;
    endcase
    return r;
  endfunction

  function automatic logic [15:0] neg16(input logic [15:0] v);
    return 16'(~v + 16'h0001);
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  dsdu_state_t state_ff;
  dsdu_state_t nxt_state;
  logic [15:0] rem_ff;
  logic [15:0] nxt_rem;
  logic [15:0] quo_ff;
  logic [15:0] nxt_quo;
  logic [15:0] dvs_ff;
  logic [15:0] nxt_dvs;
  logic [4:0]  step_ff;
  logic [4:0]  nxt_step;
  logic        signed_ff;
  logic        nxt_signed;
  logic        qneg_ff;
  logic        nxt_qneg;
  logic        rneg_ff;
  logic        nxt_rneg;
  logic        nxt_carry;
  logic        nxt_busy;
  logic        nxt_done;
  logic        load_all;
  logic        wr_en;
  logic [1:0]  wr_sel;
  logic [15:0] wr_data;
  logic [15:0] ld_zero;
  logic [15:0] ld_one;

  logic [15:0] src_val;
  logic [15:0] dst_val;
  logic [15:0] succ_val;
  logic [1:0]  succ_sel;
  logic [31:0] pair;
  logic [31:0] shifted;
  logic [5:0]  shamt;
  logic [4:0]  dsum;
  logic [15:0] hi_dvd;
  logic [31:0] dvd_mag;
  logic [16:0] trial;
  logic [15:0] q_signed;

  always_comb
  begin
    nxt_state  = state_ff;
    nxt_rem    = rem_ff;
    nxt_quo    = quo_ff;
    nxt_dvs    = dvs_ff;
    nxt_step   = step_ff;
    nxt_signed = signed_ff;
    nxt_qneg   = qneg_ff;
    nxt_rneg   = rneg_ff;
    nxt_carry  = carry_ff;
    nxt_busy   = busy_ff;
    nxt_done   = 1'b0;
    load_all   = 1'b0;
    wr_en      = 1'b0;
    wr_sel     = dst_sel;
    wr_data    = 16'h0000;
    ld_zero    = acc_zero_ff;
    ld_one     = acc_one_ff;
    src_val    = pick(src_sel, acc_zero_ff, acc_one_ff, acc_two_ff, acc_three_ff);
    dst_val    = pick(dst_sel, acc_zero_ff, acc_one_ff, acc_two_ff, acc_three_ff);
    // RL7 pair wraps
    succ_sel   = 2'(dst_sel + 2'h1);
    succ_val   = pick(succ_sel, acc_zero_ff, acc_one_ff, acc_two_ff, acc_three_ff);
    // RL8 named word high
    pair       = {dst_val, succ_val};
    // RL6 count plus one
    shamt      = {1'b0, 3'({1'b0, shift_code} + 3'h1), 2'b00};
    shifted    = 32'h0;
    dsum       = 5'h00;
    hi_dvd     = acc_zero_ff;
    dvd_mag    = 32'h0;
    trial      = {rem_ff, quo_ff[15]};
    trial      = 17'(trial - {1'b0, dvs_ff});
    q_signed   = qneg_ff ? neg16(quo_ff) : quo_ff;
    case (state_ff)
      DSDU_ST_IDLE:
      begin
        if (start)
        begin
          case (op)
            DSDU_OP_DECIMAL_DIGIT_ADD:
            begin
              // RL1 decimal digit sum
              dsum = 5'(src_val[3:0] + dst_val[3:0] + {3'h0, carry_ff});
              nxt_carry = dsum >= {1'b0, `DSDU_DEC_RADIX};
              if (nxt_carry)
                dsum = 5'(dsum + {1'b0, `DSDU_DEC_ADJ});
              // RL2 upper bits kept
              wr_en   = 1'b1;
              wr_data = {dst_val[15:4], dsum[3:0]};
              nxt_done = 1'b1;
            end
            DSDU_OP_DOUBLE_HEX_LEFT_SHIFT, DSDU_OP_DOUBLE_HEX_RIGHT_SHIFT:
            begin
              // RL4 RL5 RL9 zero-filled shift
              if (op == DSDU_OP_DOUBLE_HEX_LEFT_SHIFT)
                shifted = pair << shamt;
              else
                shifted = pair >> shamt;
              load_all = 1'b1;
              nxt_done = 1'b1;
            end
            DSDU_OP_UNSIGNED_DIVIDE:
            begin
              // RL11 overflow check first
              if (acc_zero_ff >= acc_two_ff)
              begin
                nxt_carry = 1'b1;
                nxt_done  = 1'b1;
              end
              else
              begin
                nxt_rem    = acc_zero_ff;
                nxt_quo    = acc_one_ff;
                nxt_dvs    = acc_two_ff;
                nxt_signed = 1'b0;
                nxt_qneg   = 1'b0;
                nxt_rneg   = 1'b0;
                nxt_step   = 5'h00;
                nxt_busy   = 1'b1;
                nxt_state  = DSDU_ST_DIV;
              end
            end
            DSDU_OP_SIGNED_DIVIDE_OP, DSDU_OP_SIGN_EXTEND_DIVIDE_OP:
            begin
              // RL15 extend sign first
              if (op == DSDU_OP_SIGN_EXTEND_DIVIDE_OP)
                hi_dvd = {16{acc_one_ff[15]}};
              // RL12 magnitudes for signed divide
              dvd_mag = hi_dvd[15] ? 32'(~{hi_dvd, acc_one_ff} + 32'h1) : {hi_dvd, acc_one_ff};
              nxt_rem    = dvd_mag[31:16];
              nxt_quo    = dvd_mag[15:0];
              nxt_dvs    = acc_two_ff[15] ? neg16(acc_two_ff) : acc_two_ff;
              nxt_signed = 1'b1;
              // RL13 sign rules
              nxt_qneg   = hi_dvd[15] ^ acc_two_ff[15];
              nxt_rneg   = hi_dvd[15];
              nxt_step   = 5'h00;
              nxt_busy   = 1'b1;
              if (op == DSDU_OP_SIGN_EXTEND_DIVIDE_OP)
                ld_zero = hi_dvd;
              // RL14 magnitude too big
              if (dvd_mag[31:16] >= nxt_dvs)
              begin
                nxt_carry = 1'b1;
                nxt_busy  = 1'b0;
                nxt_done  = 1'b1;
                load_all  = op == DSDU_OP_SIGN_EXTEND_DIVIDE_OP;
              end
              else
              begin
                nxt_state = DSDU_ST_DIV;
                load_all  = op == DSDU_OP_SIGN_EXTEND_DIVIDE_OP;
              end
            end
            default:
            begin
              nxt_done = 1'b1;
            end
          endcase
        end
      end
      DSDU_ST_DIV:
      begin
        // restoring division, one quotient bit per cycle
        if (rem_ff[15] || !trial[16])
          nxt_rem = trial[15:0];
        else
          nxt_rem = {rem_ff[14:0], quo_ff[15]};
        nxt_quo  = {quo_ff[14:0], rem_ff[15] || !trial[16]};
        nxt_step = 5'(step_ff + 5'h01);
        if (nxt_step == `DSDU_DIV_STEPS)
          nxt_state = DSDU_ST_FIX;
      end
      DSDU_ST_FIX:
      begin
        nxt_busy  = 1'b0;
        nxt_done  = 1'b1;
        nxt_state = DSDU_ST_DONE;
        // RL14 signed range check
        if (signed_ff && (qneg_ff ? (quo_ff > 16'h8000) : quo_ff[15]))
          nxt_carry = 1'b1;
        else
        begin
          // RL10 RL12 results placed
          nxt_carry = 1'b0;
          load_all  = 1'b1;
          ld_one    = q_signed;
          // RL13 zero stays positive
          ld_zero   = rneg_ff ? neg16(rem_ff) : rem_ff;
        end
      end
      DSDU_ST_DONE:
      begin
        nxt_state = DSDU_ST_IDLE;
      end
      default:
      begin
        nxt_state = DSDU_ST_IDLE;
        nxt_busy  = 1'b0;
      end
    endcase
  end

  // shift results are routed by pair position into the four words
  logic [15:0] ld_acc [4];
  always_comb
  begin
    ld_acc[0] = ld_zero;
    ld_acc[1] = ld_one;
    ld_acc[2] = acc_two_ff;
    ld_acc[3] = acc_three_ff;
    if (state_ff == DSDU_ST_IDLE &&
        (op == DSDU_OP_DOUBLE_HEX_LEFT_SHIFT || op == DSDU_OP_DOUBLE_HEX_RIGHT_SHIFT))
    begin
      ld_acc[0] = acc_zero_ff;
      ld_acc[1] = acc_one_ff;
      ld_acc[dst_sel]  = shifted[31:16];
      ld_acc[succ_sel] = shifted[15:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      state_ff  <= DSDU_ST_IDLE;
      rem_ff    <= 16'h0000;
      quo_ff    <= 16'h0000;
      dvs_ff    <= 16'h0000;
      step_ff   <= 5'h00;
      signed_ff <= 1'b0;
      qneg_ff   <= 1'b0;
      rneg_ff   <= 1'b0;
      carry_ff  <= 1'b0;
      busy_ff   <= 1'b0;
      done_ff   <= 1'b0;
    end
    else
    begin
      state_ff  <= nxt_state;
      rem_ff    <= nxt_rem;
      quo_ff    <= nxt_quo;
      dvs_ff    <= nxt_dvs;
      step_ff   <= nxt_step;
      signed_ff <= nxt_signed;
      qneg_ff   <= nxt_qneg;
      rneg_ff   <= nxt_rneg;
      // RL17 completion pulse
      carry_ff  <= nxt_carry;
      busy_ff   <= nxt_busy;
      done_ff   <= nxt_done;
    end
  end

  // ----------------------------------------
  // accumulators
  // ----------------------------------------
  // in_* words seed the store while idle with no start, standing in for the
  // external register file; in_carry is left unused and carry is not seeded
  logic        seed;
  assign seed = state_ff == DSDU_ST_IDLE && !start;

  dsdu_acc_file u_acc
  (
    .clk_sys        (clk_sys),
    .rst_n          (rst_n_ff),
    .load_all       (load_all || seed),
    .load_acc_zero  (seed ? in_acc_zero  : ld_acc[0]),
    .load_acc_one   (seed ? in_acc_one   : ld_acc[1]),
    .load_acc_two   (seed ? in_acc_two   : ld_acc[2]),
    .load_acc_three (seed ? in_acc_three : ld_acc[3]),
    .wr_en          (wr_en),
    .wr_sel         (wr_sel),
    .wr_data        (wr_data),
    .acc_zero_ff    (acc_zero_ff),
    .acc_one_ff     (acc_one_ff),
    .acc_two_ff     (acc_two_ff),
    .acc_three_ff   (acc_three_ff)
  );
  wire unused_carry_in = in_carry;
endmodule

/* src/dsdu_defs.svh */
// constants for the decimal, shift and divide unit
`ifndef DSDU_DEFS_SVH
`define DSDU_DEFS_SVH
`define DSDU_WORD_W      16
`define DSDU_DIGIT_W     4
`define DSDU_DEC_RADIX   4'ha
`define DSDU_DEC_ADJ     4'h6
`define DSDU_DIV_STEPS   5'h10
`define DSDU_ACC_ZERO    2'h0
`define DSDU_ACC_ONE     2'h1
`define DSDU_ACC_TWO     2'h2
`endif

/* src/dsdu_pkg.sv */
// types for the decimal, shift and divide unit
package dsdu_pkg;
  typedef enum logic [2:0]
  {
    DSDU_OP_DECIMAL_DIGIT_ADD       = 3'h0,
    DSDU_OP_DOUBLE_HEX_LEFT_SHIFT   = 3'h1,
    DSDU_OP_DOUBLE_HEX_RIGHT_SHIFT  = 3'h2,
    DSDU_OP_UNSIGNED_DIVIDE         = 3'h3,
    DSDU_OP_SIGNED_DIVIDE_OP        = 3'h4,
    DSDU_OP_SIGN_EXTEND_DIVIDE_OP   = 3'h5
  } dsdu_op_t;

  typedef enum logic [1:0]
  {
    DSDU_ST_IDLE = 2'b00,
    DSDU_ST_DIV  = 2'b01,
    DSDU_ST_FIX  = 2'b11,
    DSDU_ST_DONE = 2'b10
  } dsdu_state_t;
endpackage

/* testbench/dsdu_acc_model.sv */
// accumulator file model on the decoder side of the datapath
`timescale 1ns/100ps
module dsdu_acc_model
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        set_en,
  input  wire logic [63:0] set_vals,
  input  wire logic        done,
  input  wire logic [63:0] result,
  output logic      [15:0] in_acc_zero,
  output logic      [15:0] in_acc_one,
  output logic      [15:0] in_acc_two,
  output logic      [15:0] in_acc_three
);
  logic [63:0] acc_ff;

  // digits stay decimal
  // the bench only loads digits up to nine before a decimal add
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      acc_ff <= 64'h0;
    else if (set_en)
      acc_ff <= set_vals;
    else if (done)
      acc_ff <= result;
  end
  assign {in_acc_zero, in_acc_one, in_acc_two, in_acc_three} = acc_ff;
endmodule

/* testbench/dsdu_core_properties.sv */
// concurrent checks on the decimal, shift and divide datapath
`timescale 1ns/100ps
module dsdu_core_checker
  import dsdu_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        start,
  input wire dsdu_op_t    op,
  input wire logic [1:0]  src_sel,
  input wire logic [1:0]  dst_sel,
  input wire logic [1:0]  shift_code,
  input wire logic [15:0] acc_zero_ff,
  input wire logic [15:0] acc_one_ff,
  input wire logic [15:0] acc_two_ff,
  input wire logic [15:0] acc_three_ff,
  input wire logic        carry_ff,
  input wire logic        busy_ff,
  input wire logic        done_ff
);
  logic        taken;
  dsdu_op_t    op_ff;
  logic [1:0]  dst_ff;
  logic [31:0] exp_ff;
  logic [31:0] nxt_exp;
  logic [15:0] div_ff;
  logic [15:0] src_v;
  logic [15:0] dst_v;
  logic [4:0]  sum;
  logic [4:0]  low;
  logic [4:0]  amt;
  logic [31:0] pair;
  logic [63:0] accs;

  // words are passed in so that assertions see sampled values, not post-edge ones
  function automatic logic [15:0] pick(input logic [1:0] i, input logic [63:0] a);
    case (i)
      2'h0: return a[63:48];
      2'h1: return a[47:32];
      2'h2: return a[31:16];
      default: return a[15:0];
    endcase
  endfunction

  // ----------------------------------------
  // expected results, latched when an op is taken
  // ----------------------------------------
  assign taken = start && !busy_ff && !done_ff;
  assign accs = {acc_zero_ff, acc_one_ff, acc_two_ff, acc_three_ff};
  always_comb
  begin
    src_v = pick(src_sel, accs);
    dst_v = pick(dst_sel, accs);
    sum = {1'b0, src_v[3:0]} + {1'b0, dst_v[3:0]} + {4'h0, carry_ff};
    low = (sum > 5'h09) ? sum - 5'h0a : sum;
    amt = ({3'h0, shift_code} + 5'h01) << 2;
    pair = {dst_v, pick(2'(dst_sel + 2'h1), accs)};
    case (op)
      DSDU_OP_DECIMAL_DIGIT_ADD: nxt_exp = {15'h0000, sum > 5'h09, dst_v[15:4], low[3:0]};
      DSDU_OP_DOUBLE_HEX_LEFT_SHIFT: nxt_exp = pair << amt;
      DSDU_OP_DOUBLE_HEX_RIGHT_SHIFT: nxt_exp = pair >> amt;
      DSDU_OP_SIGN_EXTEND_DIVIDE_OP: nxt_exp = {{16{acc_one_ff[15]}}, acc_one_ff};
      default: nxt_exp = {acc_zero_ff, acc_one_ff};
    endcase
  end
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      op_ff <= DSDU_OP_DECIMAL_DIGIT_ADD;
      dst_ff <= 2'h0;
      exp_ff <= 32'h00000000;
      div_ff <= 16'h0000;
    end
    else if (taken)
    begin
      op_ff <= op;
      dst_ff <= dst_sel;
      exp_ff <= nxt_exp;
      div_ff <= acc_two_ff;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_done_one_cycle: assert property (done_ff |=> !done_ff)
    else $error("done held longer than one cycle");
  a_short_latency: assert property (taken && op inside {DSDU_OP_DECIMAL_DIGIT_ADD, DSDU_OP_DOUBLE_HEX_LEFT_SHIFT,
    DSDU_OP_DOUBLE_HEX_RIGHT_SHIFT} |=> done_ff)
    else $error("add or shift did not finish in one cycle");
  a_uns_overflow: assert property (taken && op == DSDU_OP_UNSIGNED_DIVIDE && acc_zero_ff >= acc_two_ff
    |=> done_ff && carry_ff && $stable(acc_zero_ff) && $stable(acc_one_ff))
    else $error("unsigned overflow not flagged at once");
  a_div_busy: assert property (taken && op inside {DSDU_OP_SIGNED_DIVIDE_OP, DSDU_OP_SIGN_EXTEND_DIVIDE_OP}
    |=> (done_ff && carry_ff) or (busy_ff ##[1:18] done_ff))
    else $error("signed divide did not complete in time");
  a_divisor_kept: assert property (busy_ff |-> $stable(acc_two_ff))
    else $error("divisor changed during divide");
  a_uns_result: assert property (done_ff && op_ff == DSDU_OP_UNSIGNED_DIVIDE && exp_ff[31:16] < div_ff
    |-> !carry_ff && acc_one_ff * div_ff + acc_zero_ff == exp_ff && acc_zero_ff < div_ff && acc_two_ff == div_ff)
    else $error("unsigned quotient or remainder wrong");
  a_sdiv_result: assert property (done_ff && op_ff inside {DSDU_OP_SIGNED_DIVIDE_OP, DSDU_OP_SIGN_EXTEND_DIVIDE_OP}
    && !carry_ff |-> $signed(acc_one_ff) * $signed(div_ff) + $signed(acc_zero_ff) == $signed(exp_ff)
    && (acc_zero_ff == 16'h0000 || acc_zero_ff[15] == exp_ff[31]))
    else $error("signed quotient or remainder wrong");
  a_dad_result: assert property (done_ff && op_ff == DSDU_OP_DECIMAL_DIGIT_ADD
    |-> {15'h0000, carry_ff, pick(dst_ff, accs)} == exp_ff)
    else $error("decimal digit sum wrong");
  a_shift_result: assert property (done_ff && op_ff inside {DSDU_OP_DOUBLE_HEX_LEFT_SHIFT,
    DSDU_OP_DOUBLE_HEX_RIGHT_SHIFT} |-> {pick(dst_ff, accs), pick(2'(dst_ff + 2'h1), accs)} == exp_ff)
    else $error("shifted pair wrong");

  c_dad_carry: cover property (done_ff && op_ff == DSDU_OP_DECIMAL_DIGIT_ADD && carry_ff);
  c_uns_ovf: cover property (done_ff && op_ff == DSDU_OP_UNSIGNED_DIVIDE && carry_ff);
  c_sext_done: cover property (done_ff && op_ff == DSDU_OP_SIGN_EXTEND_DIVIDE_OP);
endmodule

bind dsdu_core dsdu_core_checker chk_u (.clk_sys(clk_sys), .reset_n(reset_n), .start(start), .op(op),
  .src_sel(src_sel), .dst_sel(dst_sel), .shift_code(shift_code), .acc_zero_ff(acc_zero_ff),
  .acc_one_ff(acc_one_ff), .acc_two_ff(acc_two_ff), .acc_three_ff(acc_three_ff), .carry_ff(carry_ff),
  .busy_ff(busy_ff), .done_ff(done_ff));

/* testbench/tb.sv */
// self-checking bench for the decimal, shift and divide datapath
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
  begin check_count++; if ((got) !== (ex)) begin error_cnt++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb;
  import dsdu_pkg::*;
  localparam dsdu_op_t ADD = DSDU_OP_DECIMAL_DIGIT_ADD;
  localparam dsdu_op_t SHL = DSDU_OP_DOUBLE_HEX_LEFT_SHIFT;
  localparam dsdu_op_t SHR = DSDU_OP_DOUBLE_HEX_RIGHT_SHIFT;
  localparam dsdu_op_t UDV = DSDU_OP_UNSIGNED_DIVIDE;
  localparam dsdu_op_t SDV = DSDU_OP_SIGNED_DIVIDE_OP;
  localparam dsdu_op_t XDV = DSDU_OP_SIGN_EXTEND_DIVIDE_OP;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        start = 1'b0;
  dsdu_op_t    op = ADD;
  logic [1:0]  src_sel = 2'h0;
  logic [1:0]  dst_sel = 2'h0;
  logic [1:0]  shift_code = 2'h0;
  logic        set_en = 1'b0;
  logic [63:0] set_vals = 64'h0;
  logic [15:0] in_a0, in_a1, in_a2, in_a3;
  logic [15:0] acc_zero_ff, acc_one_ff, acc_two_ff, acc_three_ff;
  logic        carry_ff, busy_ff, done_ff;
  int          error_cnt = 0;
  int          check_count = 0;
  int          cycles = 0;

  always #2.5 clk_sys = ~clk_sys;

  dsdu_core dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .start(start), .op(op), .src_sel(src_sel),
    .dst_sel(dst_sel), .shift_code(shift_code), .in_acc_zero(in_a0), .in_acc_one(in_a1), .in_acc_two(in_a2),
    .in_acc_three(in_a3), .in_carry(1'b0), .acc_zero_ff(acc_zero_ff), .acc_one_ff(acc_one_ff),
    .acc_two_ff(acc_two_ff), .acc_three_ff(acc_three_ff), .carry_ff(carry_ff), .busy_ff(busy_ff),
    .done_ff(done_ff));
  dsdu_acc_model acc_u (.clk_sys(clk_sys), .reset_n(reset_n), .set_en(set_en), .set_vals(set_vals),
    .done(done_ff), .result({acc_zero_ff, acc_one_ff, acc_two_ff, acc_three_ff}), .in_acc_zero(in_a0),
    .in_acc_one(in_a1), .in_acc_two(in_a2), .in_acc_three(in_a3));

  // ----------------------------------------
  // one operation: load, idle seed cycle, start pulse, wait for done
  // ----------------------------------------
  task automatic run(input dsdu_op_t o, input logic [1:0] s, input logic [1:0] d, input logic [1:0] n,
                     input logic [63:0] vin, input logic [63:0] vexp, input logic cexp, input logic chk_acc);
    int k;
    @(posedge clk_sys);
    set_en <= 1'b1;
    set_vals <= vin;
    op <= o;
    src_sel <= s;
    dst_sel <= d;
    shift_code <= n;
    @(posedge clk_sys);
    set_en <= 1'b0;
    @(posedge clk_sys);
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    k = 0;
    do
    begin
      @(negedge clk_sys);
      k++;
    end while (done_ff !== 1'b1 && k < 30);
    `CHK("done", 1'b1, done_ff)
    if (chk_acc)
      `CHK("accs", vexp, {acc_zero_ff, acc_one_ff, acc_two_ff, acc_three_ff})
    `CHK("carry", cexp, carry_ff)
  endtask

  task automatic t_add();
    run(ADD, 2'h2, 2'h3, 2'h0, 64'h0000_0000_1239_abc7, 64'h0000_0000_1239_abc6, 1'b1, 1'b1);
    run(ADD, 2'h0, 2'h1, 2'h0, 64'h0004_5555_0000_0000, 64'h0004_5550_0000_0000, 1'b1, 1'b1);
    run(ADD, 2'h1, 2'h0, 2'h0, 64'hfff0_0000_0000_0000, 64'hfff1_0000_0000_0000, 1'b0, 1'b1);
    $display("test add done");
  endtask

  task automatic t_shift();
    logic [15:0] w [4];
    logic [31:0] p;
    logic [1:0]  d;
    run(SHL, 2'h0, 2'h0, 2'h0, 64'h0270_5008_0000_0000, 64'h2705_0080_0000_0000, 1'b0, 1'b1);
    run(SHR, 2'h0, 2'h0, 2'h1, 64'h0270_5008_0000_0000, 64'h0002_7050_0000_0000, 1'b0, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      w = '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0};
      d = 2'(i >> 1);
      p = {w[d], w[d + 2'h1]};
      p = i[0] ? p >> (4 * (int'(d) + 1)) : p << (4 * (int'(d) + 1));
      w[d] = p[31:16];
      w[d + 2'h1] = p[15:0];
      run(i[0] ? SHR : SHL, 2'h0, d, d, 64'h1234_5678_9abc_def0, {w[0], w[1], w[2], w[3]}, 1'b0, 1'b1);
    end
    $display("test shift done");
  endtask

  task automatic t_udiv();
    run(UDV, 2'h0, 2'h0, 2'h0, 64'h0000_0006_0002_00aa, 64'h0000_0003_0002_00aa, 1'b0, 1'b1);
    run(UDV, 2'h0, 2'h0, 2'h0, 64'h0000_0007_0002_00aa, 64'h0001_0003_0002_00aa, 1'b0, 1'b1);
    run(UDV, 2'h0, 2'h0, 2'h0, 64'h3fff_0001_7fff_0000, 64'h0000_7fff_7fff_0000, 1'b0, 1'b1);
    run(UDV, 2'h0, 2'h0, 2'h0, 64'hfffe_0001_7fff_00aa, 64'hfffe_0001_7fff_00aa, 1'b1, 1'b1);
    run(UDV, 2'h0, 2'h0, 2'h0, 64'h7fff_0001_7fff_00aa, 64'h7fff_0001_7fff_00aa, 1'b1, 1'b1);
    $display("test udiv done");
  endtask

  task automatic t_sdiv();
    run(SDV, 2'h0, 2'h0, 2'h0, 64'hffff_fff9_fffe_0000, 64'hffff_0003_fffe_0000, 1'b0, 1'b1);
    run(SDV, 2'h0, 2'h0, 2'h0, 64'h0000_0007_fffe_0000, 64'h0001_fffd_fffe_0000, 1'b0, 1'b1);
    run(SDV, 2'h0, 2'h0, 2'h0, 64'hffff_fff9_0002_0000, 64'hffff_fffd_0002_0000, 1'b0, 1'b1);
    run(SDV, 2'h0, 2'h0, 2'h0, 64'hffff_fff8_0002_0000, 64'h0000_fffc_0002_0000, 1'b0, 1'b1);
    run(SDV, 2'h0, 2'h0, 2'h0, 64'hffff_0000_0002_0000, 64'h0000_8000_0002_0000, 1'b0, 1'b1);
    run(SDV, 2'h0, 2'h0, 2'h0, 64'h0001_0000_0001_0000, 64'h0, 1'b1, 1'b0);
    $display("test sdiv done");
  endtask

  task automatic t_sext();
    run(XDV, 2'h0, 2'h0, 2'h0, 64'h1234_fff9_fffe_0000, 64'hffff_0003_fffe_0000, 1'b0, 1'b1);
    run(XDV, 2'h0, 2'h0, 2'h0, 64'hffff_0007_0002_0000, 64'h0001_0003_0002_0000, 1'b0, 1'b1);
    run(XDV, 2'h0, 2'h0, 2'h0, 64'h0000_8000_ffff_0000, 64'h0, 1'b1, 1'b0);
    $display("test sext done");
  endtask

  task automatic results();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      $display("ERROR timeout expected finish seen hang");
      results();
    end
  end

  initial
  begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_add();
    t_shift();
    t_udiv();
    t_sdiv();
    t_sext();
    results();
  end
endmodule
